// ===== rtl/digital_io.sv
// digital i/o block: two configurable status pins, remote enable, strobes
`timescale 1ns/100ps

//
// Overview of operation
// - two output pins, index 0 and 1, each with its own function
// - general purpose function drives the software level high or low
// - output-state function shows power output enabled as 1
// - form function shows 1 for single phase, 0 for split or three
// - fault function shows 1 while a fault exists
// - transient function shows 1 while running, paused or stepping
// - program function shows 1 under remote control, 0 local
// - the list of selectable functions can be read
// - each pin has polarity: 1 inverts, 0 normal
// - function and polarity of a pin read back together
// - the level actually driven on each pin reads back as one bit
// - remote enable state bit is writable and readable
// - auto 1: output enables at once when remote enable and input are 1
// - auto 0: input rising edge enables output, falling edge disables
// - auto setting defaults to 1
// - remote inhibit state bit is writable and readable
// - strobe on relay change when enabled
// - strobe on programmed setting change when enabled
// - strobe at start of each transient when enabled
module digital_io
   import digital_io_pkg::*;
#(
   parameter int NUM_PINS     = 2,
   parameter int STROBE_WIDTH = STROBE_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                remote_in,
   input  wire logic                form_single,
   input  wire logic                fault_active,
   input  wire logic                transient_active,
   input  wire logic                remote_control,
   input  wire logic                coupling_active,
   input  wire logic                program_change,
   input  wire logic                transient_start,
   output logic [NUM_PINS-1:0]      digital_io_out,
   output logic                     power_enable,
   output logic                     remote_inhibit
);

   ////////////////////////////////////////////////////////////////////////////
   logic [3:0]          pin_fn_q  [NUM_PINS];
   logic [NUM_PINS-1:0] pin_inv_q;
   logic [NUM_PINS-1:0] pin_q;
   logic                remote_ena_q;
   logic                remote_auto_q;
   logic                inhibit_q;
   logic                sw_on_q;
   logic                power_q;
   logic                power_prev_q;
   logic                pulse_on_relay_change_q;
   logic                strobe_prog_q;
   logic                strobe_tran_q;
   logic                rem_meta_q;
   logic                rem_sync_q;
   logic                rem_prev_q;
   logic                boot_q;
   logic [15:0]         strobe_cnt_q;
   logic                strobe_q;
   logic                pready_q;
   logic                pslverr_q;
   logic [31:0]         prdata_q;
   logic                wr_take;
   logic                setup;
   logic                addr_ok;
   logic                sanitize;
   logic                strobe_fire;
   logic                power_d;
   logic [31:0]         rd_d;

   assign setup    = psel && !penable && clk_en;
   assign wr_take  = psel && penable && pready_q && pwrite && clk_en && !pslverr_q;
   assign sanitize = wr_take && (paddr == ADDR_SANITIZE) && pwdata[0];

   always_comb begin
      addr_ok = 1'b1;
      rd_d    = 32'h0000_0000;
      unique case (paddr)
         ADDR_PIN0, ADDR_PIN1: begin
            rd_d[PIN_FN_LSB +: PIN_FN_W] = pin_fn_q[paddr[2]];
            rd_d[PIN_INV_BIT]            = pin_inv_q[paddr[2]];
         end
         ADDR_LEVEL: begin
            rd_d[NUM_PINS-1:0] = pin_q;
         end
         ADDR_REMOTE: begin
            rd_d[REM_ENA_BIT]   = remote_ena_q;
            rd_d[REM_AUTO_BIT]  = remote_auto_q;
            rd_d[REM_INH_BIT]   = inhibit_q;
            rd_d[REM_SWON_BIT]  = sw_on_q;
            rd_d[REM_POWER_BIT] = power_q;
         end
         ADDR_STROBE: begin
            rd_d[STB_RELAY_BIT] = pulse_on_relay_change_q;
            rd_d[STB_PROG_BIT]  = strobe_prog_q;
            rd_d[STB_TRAN_BIT]  = strobe_tran_q;
         end
         ADDR_CATALOG: begin
            rd_d[9:0] = CATALOG_MASK;
         end
         ADDR_SANITIZE: rd_d = 32'h0000_0000;
         default:       addr_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb: no wait states; read data and pready come from flops loaded in the setup cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready_q  <= setup;
         if (setup) begin
            pslverr_q <= !addr_ok;
            prdata_q  <= (!pwrite && addr_ok) ? rd_d : 32'h0000_0000;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // per-pin configuration
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pin_fn_q[i] <= RST_PIN_FN;
         end
         pin_inv_q <= {NUM_PINS{RST_PIN_INV}};
      end else if (wr_take && (paddr == ADDR_PIN0 || paddr == ADDR_PIN1)) begin
         pin_fn_q[paddr[2]]  <= pwdata[PIN_FN_LSB +: PIN_FN_W];
         pin_inv_q[paddr[2]] <= pwdata[PIN_INV_BIT];
      end
   end

   // remote enable, auto and inhibit state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         remote_ena_q  <= RST_REMOTE_ENA;
         remote_auto_q <= RST_REMOTE_AUTO;
         inhibit_q     <= RST_INHIBIT;
         sw_on_q       <= 1'b0;
      end else if (sanitize) begin
         remote_ena_q  <= RST_REMOTE_ENA;
         remote_auto_q <= RST_REMOTE_AUTO;
      end else if (wr_take && paddr == ADDR_REMOTE) begin
         remote_ena_q  <= pwdata[REM_ENA_BIT];
         remote_auto_q <= pwdata[REM_AUTO_BIT];
         inhibit_q     <= pwdata[REM_INH_BIT];
         sw_on_q       <= pwdata[REM_SWON_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         {strobe_tran_q, strobe_prog_q, pulse_on_relay_change_q} <= RST_STROBE_CFG;
      end else if (wr_take && paddr == ADDR_STROBE) begin
         pulse_on_relay_change_q <= pwdata[STB_RELAY_BIT];
         strobe_prog_q           <= pwdata[STB_PROG_BIT];
         strobe_tran_q           <= pwdata[STB_TRAN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // remote input pin crosses in through two flops
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rem_meta_q <= 1'b0;
         rem_sync_q <= 1'b0;
         rem_prev_q <= 1'b0;
         boot_q     <= 1'b1;
      end else if (clk_en) begin
         rem_meta_q <= remote_in;
         rem_sync_q <= rem_meta_q;
         rem_prev_q <= rem_sync_q;
         boot_q     <= 1'b0;
      end
   end

   // edge mode keeps the last edge's decision; switching auto off freezes the
   // present state until the next edge rather than dropping the output
   always_comb begin
      power_d = power_q;
      if (inhibit_q) begin
         power_d = 1'b0;
      end else if (!remote_ena_q) begin
         power_d = sw_on_q;
      end else if (remote_auto_q) begin
         power_d = rem_sync_q;
      end else if (!boot_q && rem_sync_q && !rem_prev_q) begin
         power_d = 1'b1;
      end else if (!boot_q && !rem_sync_q && rem_prev_q) begin
         power_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         power_q      <= 1'b0;
         power_prev_q <= 1'b0;
      end else if (clk_en) begin
         power_q      <= power_d;
         power_prev_q <= power_q;
      end
   end

   assign power_enable   = power_q;
   assign remote_inhibit = inhibit_q;

   ////////////////////////////////////////////////////////////////////////////
   // strobe pulse; a new trigger during a pulse restarts it
   assign strobe_fire = (pulse_on_relay_change_q && (power_q != power_prev_q))
                     || (strobe_prog_q && program_change)
                     || (strobe_tran_q && transient_start);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         strobe_cnt_q <= 16'h0000;
         strobe_q     <= 1'b0;
      end else if (clk_en) begin
         if (strobe_fire) begin
            strobe_cnt_q <= 16'(STROBE_WIDTH - 1);
            strobe_q     <= 1'b1;
         end else if (strobe_cnt_q != 16'h0000) begin
            strobe_cnt_q <= strobe_cnt_q - 16'h0001;
         end else begin
            strobe_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      logic src;

      always_comb begin
         unique case (pin_fn_q[g])
            FN_LOW:          src = 1'b0;
            FN_HIGH:         src = 1'b1;
            FN_OUTPUT_STATE: src = power_q;
            FN_FORM:         src = form_single;
            FN_FAULT:        src = fault_active;
            FN_TRANSIENT:    src = transient_active;
            FN_PROGRAM:      src = remote_control;
            FN_COUPLING:     src = coupling_active;
            FN_REMOTE:       src = rem_sync_q;
            FN_STROBE:       src = strobe_q;
            default:         src = 1'b0;
         endcase
      end

      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            pin_q[g] <= 1'b0;
         end else if (clk_en) begin
            pin_q[g] <= src ^ pin_inv_q[g];
         end
      end
   end

   assign digital_io_out = pin_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence wr_pin0_fault_s;
      wr_take && paddr == ADDR_PIN0 && pwdata[3:0] == 4'(FN_FAULT) && !pwdata[PIN_INV_BIT];
   endsequence

   sequence fault_seen_s;
      clk_en [*2] ##0 (digital_io_out[0] == $past(fault_active));
   endsequence

   pin_fault_a: assert property (
      wr_pin0_fault_s ##1 clk_en |-> ##1 (digital_io_out[0] == $past(fault_active)))
      else $error("pin 0 does not follow fault");

   pin_invert_a: assert property (
      clk_en && pin_fn_q[1] == 4'(FN_HIGH) && pin_inv_q[1] |=> !digital_io_out[1])
      else $error("inverted high pin not low");

   pin_state_a: assert property (
      clk_en && pin_fn_q[0] == 4'(FN_OUTPUT_STATE) && !pin_inv_q[0]
      |=> digital_io_out[0] == $past(power_enable))
      else $error("pin does not show output state");

   auto_level_a: assert property (
      clk_en && remote_ena_q && remote_auto_q && !inhibit_q && rem_sync_q
      |=> power_enable)
      else $error("level mode did not enable");

   edge_hold_a: assert property (
      clk_en && remote_ena_q && !remote_auto_q && !inhibit_q && !boot_q
      && rem_sync_q == rem_prev_q |=> $stable(power_enable))
      else $error("edge mode changed without edge");

   inhibit_off_a: assert property (
      clk_en && inhibit_q |=> !power_enable)
      else $error("inhibit did not hold output off");

   sanitize_val_a: assert property (
      sanitize |=> remote_auto_q && !remote_ena_q)
      else $error("sanitize values wrong");

   strobe_len_a: assert property (
      clk_en && strobe_fire ##1 (clk_en && !strobe_fire) [*8] |-> strobe_q)
      else $error("strobe pulse too short");

   strobe_relay_a: assert property (
      clk_en && pulse_on_relay_change_q && $changed(power_prev_q) |=> strobe_q)
      else $error("no strobe on relay change");

   level_read_a: assert property (
      setup && !pwrite && paddr == ADDR_LEVEL |=> prdata[NUM_PINS-1:0] == $past(pin_q) && pready)
      else $error("level readback wrong");

endmodule

// ===== rtl/digital_io_pkg.sv
// register map, field layout, reset values and timing for the digital i/o block
package digital_io_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_PIN0     = 8'h00;
   localparam logic [7:0] ADDR_PIN1     = 8'h04;
   localparam logic [7:0] ADDR_LEVEL    = 8'h08;
   localparam logic [7:0] ADDR_REMOTE   = 8'h0C;
   localparam logic [7:0] ADDR_STROBE   = 8'h10;
   localparam logic [7:0] ADDR_CATALOG  = 8'h14;
   localparam logic [7:0] ADDR_SANITIZE = 8'h18;

   // pin configuration register fields
   localparam int PIN_FN_LSB  = 0;
   localparam int PIN_FN_W    = 4;
   localparam int PIN_INV_BIT = 4;

   // remote register fields
   localparam int REM_ENA_BIT   = 0;
   localparam int REM_AUTO_BIT  = 1;
   localparam int REM_INH_BIT   = 2;
   localparam int REM_SWON_BIT  = 3;
   localparam int REM_POWER_BIT = 4;

   // strobe register fields
   localparam int STB_RELAY_BIT = 0;
   localparam int STB_PROG_BIT  = 1;
   localparam int STB_TRAN_BIT  = 2;

   // selectable pin functions
   typedef enum logic [3:0] {
      FN_LOW,
      FN_HIGH,
      FN_OUTPUT_STATE,
      FN_FORM,
      FN_FAULT,
      FN_TRANSIENT,
      FN_PROGRAM,
      FN_COUPLING,
      FN_REMOTE,
      FN_STROBE
   } pin_fn_t;

   // values after reset; sanitize restores only RST_REMOTE_ENA and RST_REMOTE_AUTO
   localparam logic [3:0] RST_PIN_FN      = 4'h2;
   localparam logic       RST_PIN_INV     = 1'b0;
   localparam logic       RST_REMOTE_ENA  = 1'b0;
   localparam logic       RST_REMOTE_AUTO = 1'b1;
   localparam logic       RST_INHIBIT     = 1'b0;
   localparam logic [2:0] RST_STROBE_CFG  = 3'h0;

   // one bit per selectable function
   localparam logic [9:0] CATALOG_MASK = 10'h3FF;

   // strobe pulse width
   localparam int CLK_HZ         = 40_000_000;
   localparam int STROBE_NS      = 10_000;
   localparam int STROBE_CYCLES  = (STROBE_NS * (CLK_HZ / 1_000_000)) / 1000;

endpackage

// ===== tb/ext_equipment.sv
// external equipment on the digital i/o pins: remote contact and pulse timer
`timescale 1ns/100ps
module ext_equipment (
   input  wire logic       sys_clk,
   input  wire logic       remote_req,
   input  wire logic [1:0] pin_level,
   output logic            remote_in,
   output int              pulse_len
);
   int run;
   initial begin
      remote_in = 1'b0;
      pulse_len = 0;
      run       = 0;
   end
   // the contact moves only on a clock edge here; the block resyncs it anyway
   always @(posedge sys_clk) begin
      remote_in <= remote_req;
   end
   // width in cycles of the last high pulse on the first pin
   always @(posedge sys_clk) begin
      if (pin_level[0] === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         pulse_len <= run;
         run       <= 0;
      end
   end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the digital i/o block
`timescale 1ns/100ps
module tb_top;
   import digital_io_pkg::*;
   localparam int SW = 8;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        remote_req, remote_in, form_single, fault_active, transient_active;
   logic        remote_control, coupling_active, program_change, transient_start;
   logic [1:0]  digital_io_out;
   logic        power_enable, remote_inhibit;
   int          pulse_len, n_mismatch, compares;
   logic [31:0] seed = 32'h00006F91;
   logic [3:0]  cfn [2];
   logic        cinv [2];

   digital_io #(.STROBE_WIDTH(SW)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .remote_in(remote_in),
      .form_single(form_single), .fault_active(fault_active),
      .transient_active(transient_active), .remote_control(remote_control),
      .coupling_active(coupling_active), .program_change(program_change),
      .transient_start(transient_start), .digital_io_out(digital_io_out),
      .power_enable(power_enable), .remote_inhibit(remote_inhibit));
   ext_equipment ext_u (.sys_clk(sys_clk), .remote_req(remote_req),
      .pin_level(digital_io_out), .remote_in(remote_in), .pulse_len(pulse_len));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // s: power, form, fault, transient, remote ctl, coupling, remote input
   function automatic logic pin_exp(input logic [3:0] fn, input logic inv, input logic [7:0] s);
      logic v;
      v = (fn == 4'h1) ? 1'b1 : (fn >= 4'h2 && fn <= 4'h8) ? s[fn-4'h2] : 1'b0;
      return v ^ inv;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // pready is looked at mid-cycle, before the edge that samples it
      @(negedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 20) n_mismatch++;
      r = prdata;
      err = pslverr;
      @(posedge sys_clk);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, experr});
   endtask
   task automatic test_done();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      n_mismatch++;
      test_done();
   end

   initial begin
      logic [7:0] s;
      logic [3:0] fn;
      logic       inv;
      int         p, k;
      n_mismatch = 0; compares = 0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; remote_req = 1'b0; form_single = 1'b0;
      fault_active = 1'b0; transient_active = 1'b0; remote_control = 1'b0;
      coupling_active = 1'b0; program_change = 1'b0; transient_start = 1'b0;
      cfn[0] = RST_PIN_FN; cfn[1] = RST_PIN_FN; cinv[0] = 1'b0; cinv[1] = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdchk(ADDR_PIN1, {27'h0, RST_PIN_INV, RST_PIN_FN}, 1'b0);
      rdchk(ADDR_REMOTE, 32'h00000002, 1'b0);
      rdchk(ADDR_CATALOG, {22'h0, CATALOG_MASK}, 1'b0);
      rdchk(8'h1C, 32'h0, 1'b1);
      // every function code, both pins, random status and polarity
      for (k = 0; k < 33; k++) begin
         s = rnd();
         p = k % 2;
         fn = 4'(k % 11);
         inv = s[7];
         form_single <= s[1]; fault_active <= s[2]; transient_active <= s[3];
         remote_control <= s[4]; coupling_active <= s[5]; remote_req <= s[6];
         wr(ADDR_REMOTE, {28'h0, s[0], 3'b010});
         wr(p ? ADDR_PIN1 : ADDR_PIN0, {27'h0, inv, fn});
         cfn[p] = fn;
         cinv[p] = inv;
         repeat (6) @(posedge sys_clk);
         chk({31'h0, digital_io_out[p]}, {31'h0, pin_exp(fn, inv, s)});
         rdchk(ADDR_LEVEL, {30'h0, pin_exp(cfn[1], cinv[1], s), pin_exp(cfn[0], cinv[0], s)}, 1'b0);
         rdchk(p ? ADDR_PIN1 : ADDR_PIN0, {27'h0, inv, fn}, 1'b0);
      end
      // remote enable, level mode then edge mode, then inhibit
      remote_req <= 1'b0;
      wr(ADDR_REMOTE, 32'h00000003);
      repeat (6) @(posedge sys_clk);
      chk({31'h0, power_enable}, 32'h0);
      remote_req <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({31'h0, power_enable}, 32'h1);
      remote_req <= 1'b0;
      repeat (6) @(posedge sys_clk);
      wr(ADDR_REMOTE, 32'h00000001);
      remote_req <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({31'h0, power_enable}, 32'h1);
      remote_req <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk({31'h0, power_enable}, 32'h0);
      remote_req <= 1'b1;
      wr(ADDR_REMOTE, 32'h00000007);
      repeat (6) @(posedge sys_clk);
      chk({30'h0, remote_inhibit, power_enable}, 32'h2);
      rdchk(ADDR_REMOTE, 32'h00000007, 1'b0);
      wr(ADDR_SANITIZE, 32'h00000001);
      rdchk(ADDR_REMOTE, 32'h00000006, 1'b0);
      // strobes from relay change, program change and transient start
      remote_req <= 1'b0;
      wr(ADDR_REMOTE, 32'h00000002);
      wr(ADDR_PIN0, 32'h00000009);
      wr(ADDR_STROBE, 32'h00000007);
      for (k = 0; k < 3; k++) begin
         if (k == 0) begin
            wr(ADDR_REMOTE, 32'h0000000A);
         end else begin
            program_change <= (k == 1);
            transient_start <= (k == 2);
            @(posedge sys_clk);
            program_change <= 1'b0;
            transient_start <= 1'b0;
         end
         repeat (SW + 8) @(posedge sys_clk);
         chk({31'h0, digital_io_out[0]}, 32'h0);
         chk({31'h0, (pulse_len == SW || pulse_len == SW + 1)}, 32'h1);
      end
      test_done();
   end
endmodule
